// file: rtl/fdo_option_logic.sv
// Option logic of a flexible disk drive: select decode, head load, side, status gating.
// Assumes cable inputs are asynchronous and configuration is written over APB before use.
// What this block does
// [R1] Multiplex mode: select line 1 strobes lines 2,3,4 as weights 1,2,4.
// [R2] Multiplex: selected when line 1 low and low address lines equal strap.
// [R3] Default: selection loads heads and powers stepper.
// [R4] Option one: select enables status; head-load input loads heads and powers stepper while selected.
// [R5] Option two: select powers stepper without loading heads.
// [R6] Option three: head-load input loads heads, no select, no stepper.
// [R7] Default head choice comes from the side select input.
// [R8] Side option one: direction chooses head; stepping needs a step pulse.
// [R9] Side option two: four select lines address two double-sided drives.
// [R10] Ready gated by select, or driven always on alternate output.
// [R11] Index gated by select, or driven always on alternate output.
// [R12] Default in-use lamp lit while select active.
// [R13] Default: door solenoid on only while select and ready both active.
// [R14] In-use and head-load inputs active low.
// [R15] In-use option one: lamp from select or in-use input.
// [R16] In-use option two: lamp from head-load or in-use input.
// [R17] In-use option three: lamp from in-use input only.
// [R18] Door latch option holds lock once started, until ready drops.
// [R19] Write override: protected disk does not block writing, still reported.
// [R20] Disk-change goes low when ready drops after select deasserted.
// [R21] Disk-change cleared on select falling edge (deselect) if ready.
// [R22] Two-sided output low for double-sided disk while selected.
// [R23] Factory: write blocked when disk write protected.
// [R24] Disk-change inactive high at reset; options are static configuration.
`timescale 1ns/100ps
module fdo_option_logic (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire fdo_pkg::fdo_ctl_s CTL,
    input wire fdo_pkg::fdo_mech_s MECH,
    output logic HEAD_LOAD,
    output logic STEPPER_ON,
    output logic HEAD_SIDE,
    output logic STEP_PULSE,
    output logic STEP_DIR_IN,
    output logic WRITE_ENABLE,
    output logic READY_N,
    output logic INDEX_N,
    output logic READY_ALT_N,
    output logic INDEX_ALT_N,
    output logic PROTECT_N,
    output logic IN_USE_LAMP,
    output logic DOOR_LOCK,
    output logic DISK_CHANGE_N,
    output logic TWO_SIDED_N
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int CTL_W = $bits(fdo_pkg::fdo_ctl_s);
    localparam int MECH_W = $bits(fdo_pkg::fdo_mech_s);
    logic [CTL_W-1:0] ctl_meta_reg;
    logic [CTL_W-1:0] ctl_sync_reg;
    logic [MECH_W-1:0] mech_meta_reg;
    logic [MECH_W-1:0] mech_sync_reg;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_meta_reg <= '1;
            ctl_sync_reg <= '1;
            mech_meta_reg <= '0;
            mech_sync_reg <= '0;
        end else begin
            ctl_meta_reg <= CTL;
            ctl_sync_reg <= ctl_meta_reg;
            mech_meta_reg <= MECH;
            mech_sync_reg <= mech_meta_reg;
        end
    end

    fdo_pkg::fdo_ctl_s ctl;
    fdo_pkg::fdo_mech_s mech;
    assign ctl = fdo_pkg::fdo_ctl_s'(ctl_sync_reg);
    assign mech = fdo_pkg::fdo_mech_s'(mech_sync_reg);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave
    logic [fdo_pkg::FDO_CFG_W-1:0] cfg_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic pready_reg;

    wire apb_setup = PSEL && !PENABLE;
    wire hit_cfg = PADDR == fdo_pkg::FDO_OFS_CFG;
    wire hit_status = PADDR == fdo_pkg::FDO_OFS_STATUS;
    wire hit_door = PADDR == fdo_pkg::FDO_OFS_DOOR;
    wire hit_any = hit_cfg || hit_status || hit_door;
    wire cfg_write = PSEL && PENABLE && PWRITE && hit_cfg;

    fdo_pkg::fdo_cfg_s cfg;
    assign cfg = fdo_pkg::fdo_cfg_s'(cfg_reg);

    logic [31:0] status_word;
    logic [31:0] read_mux;
    assign read_mux = hit_cfg ? {{(32 - fdo_pkg::FDO_CFG_W){1'b0}}, cfg_reg}
        : hit_status ? status_word
        : hit_door ? {31'h0, DOOR_LOCK}
        : 32'h0;

    // Configuration is static once written; zero-wait-state answer
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_reg <= fdo_pkg::FDO_CFG_RESET; // R24
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !hit_any;
            if (apb_setup) begin
                prdata_reg <= PWRITE ? 32'h0 : read_mux;
            end
            if (cfg_write && pready_reg) begin
                cfg_reg <= PWDATA[fdo_pkg::FDO_CFG_W-1:0]; // R24
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Select decode
    wire [2:0] addr_lines = ~ctl.select_n[3:1]; // R1
    wire multiplex_compare_enable = !ctl.select_n[0]; // R1
    wire mux_selected = multiplex_compare_enable && (addr_lines == cfg.multiplex_address); // R2
    wire daisy_selected = !ctl.select_n[cfg.daisy_position];
    // Drive one owns lines 1,2; drive two owns lines 3,4
    wire [1:0] pair_lines = cfg.daisy_position[1] ? ~ctl.select_n[3:2] : ~ctl.select_n[1:0];
    wire pair_selected = |pair_lines; // R9
    wire pair_head = pair_lines[1]; // R9

    logic selected;
    always_comb begin
        case (cfg.sel_mode)
            fdo_pkg::FDO_SEL_MULTIPLEX: selected = mux_selected;
            fdo_pkg::FDO_SEL_TWO_DOUBLE: selected = pair_selected;
            default: selected = daisy_selected;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Head load and stepper
    wire head_load_in = !ctl.head_load_n; // R14
    wire in_use_in = !ctl.in_use_n; // R14
    logic load_next;
    logic stepper_next;
    logic status_enable;
    always_comb begin
        case (cfg.hl_mode)
            fdo_pkg::FDO_HL_OPT1: begin
                load_next = selected && head_load_in; // R4
                stepper_next = selected && head_load_in; // R4
                status_enable = selected; // R4
            end
            fdo_pkg::FDO_HL_OPT2: begin
                load_next = selected && head_load_in; // R5
                stepper_next = selected; // R5
                status_enable = selected;
            end
            fdo_pkg::FDO_HL_OPT3: begin
                load_next = head_load_in; // R6
                stepper_next = 1'b0; // R6
                status_enable = selected;
            end
            default: begin
                load_next = selected; // R3
                stepper_next = selected; // R3
                status_enable = selected;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Side select
    logic side_next;
    always_comb begin
        case (cfg.side_mode)
            fdo_pkg::FDO_SIDE_DIRECTION: side_next = !ctl.direction_n; // R8
            fdo_pkg::FDO_SIDE_SELECT_LINES: side_next = pair_head; // R9
            default: side_next = !ctl.side_n; // R7
        endcase
    end
    // Motion only on a step pulse, so direction may carry side during transfers
    logic step_prev_reg;
    wire step_fall = step_prev_reg && ctl.step_n == 1'b0;
    wire step_next = step_fall && stepper_next; // R8

    ////////////////////////////////////////////////////////////////////////////
    // In-use lamp and door lock
    logic lamp_next;
    always_comb begin
        case (cfg.iu_mode)
            fdo_pkg::FDO_IU_OPT1: lamp_next = selected || in_use_in; // R15
            fdo_pkg::FDO_IU_OPT2: lamp_next = head_load_in || in_use_in; // R16
            fdo_pkg::FDO_IU_OPT3: lamp_next = in_use_in; // R17
            default: lamp_next = selected; // R12
        endcase
    end

    logic door_latch_reg;
    wire lock_start = cfg.door_latch_enable ? (in_use_in || selected) && mech.ready
        : selected && mech.ready;
    // Latch holds until the drive drops ready
    wire door_latch_next = cfg.door_latch_enable && mech.ready && (door_latch_reg || lock_start); // R18
    wire door_next = (selected && mech.ready) || door_latch_next; // R13

    ////////////////////////////////////////////////////////////////////////////
    // Write protect and disk change
    wire write_next = !ctl.write_gate_n && selected && load_next
        && (cfg.allow_write_protected || !mech.protect); // R19 R23

    logic sel_prev_reg;
    logic ready_prev_reg;
    logic change_reg;
    wire sel_release = sel_prev_reg && !selected;
    wire ready_drop = ready_prev_reg && !mech.ready;
    // Set wins over clear
    wire change_next = (ready_drop && !selected) ? 1'b1 // R20
        : (sel_release && mech.ready) ? 1'b0 // R21
        : change_reg;

    assign status_word = {25'h0, change_reg, mech.two_sided, mech.protect,
        mech.index, mech.ready, selected, door_latch_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HEAD_LOAD <= 1'b0;
            STEPPER_ON <= 1'b0;
            HEAD_SIDE <= 1'b0;
            STEP_PULSE <= 1'b0;
            STEP_DIR_IN <= 1'b0;
            WRITE_ENABLE <= 1'b0;
            READY_N <= 1'b1;
            INDEX_N <= 1'b1;
            READY_ALT_N <= 1'b1;
            INDEX_ALT_N <= 1'b1;
            PROTECT_N <= 1'b1;
            IN_USE_LAMP <= 1'b0;
            DOOR_LOCK <= 1'b0;
            DISK_CHANGE_N <= 1'b1; // R24
            TWO_SIDED_N <= 1'b1;
            step_prev_reg <= 1'b1;
            sel_prev_reg <= 1'b0;
            ready_prev_reg <= 1'b0;
            change_reg <= 1'b0; // R24
            door_latch_reg <= 1'b0;
        end else begin
            HEAD_LOAD <= load_next;
            STEPPER_ON <= stepper_next;
            HEAD_SIDE <= side_next;
            STEP_PULSE <= step_next; // R8
            STEP_DIR_IN <= !ctl.direction_n;
            WRITE_ENABLE <= write_next; // R23
            READY_N <= !(status_enable && mech.ready); // R10
            INDEX_N <= !(status_enable && mech.index); // R11
            READY_ALT_N <= !(cfg.radial_ready && mech.ready); // R10
            INDEX_ALT_N <= !(cfg.radial_index && mech.index); // R11
            PROTECT_N <= !(status_enable && mech.protect); // R19
            IN_USE_LAMP <= lamp_next;
            DOOR_LOCK <= door_next; // R13
            DISK_CHANGE_N <= !change_next; // R20
            TWO_SIDED_N <= !(status_enable && mech.two_sided); // R22
            step_prev_reg <= ctl.step_n;
            sel_prev_reg <= selected;
            ready_prev_reg <= mech.ready;
            change_reg <= change_next;
            door_latch_reg <= door_latch_next;
        end
    end

endmodule

// file: rtl/fdo_pkg.sv
// Package for the floppy drive option logic: strap encodings, carrier structs, APB map.
// Assumes a 32-bit APB slave and a 100 MHz core clock.
package fdo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Select mode
    typedef enum logic [1:0] {
        FDO_SEL_DAISY,
        FDO_SEL_MULTIPLEX,
        FDO_SEL_TWO_DOUBLE
    } fdo_sel_mode_e;

    // Head load option
    typedef enum logic [1:0] {
        FDO_HL_DEFAULT,
        FDO_HL_OPT1,
        FDO_HL_OPT2,
        FDO_HL_OPT3
    } fdo_hl_mode_e;

    // Side select source
    typedef enum logic [1:0] {
        FDO_SIDE_LINE,
        FDO_SIDE_DIRECTION,
        FDO_SIDE_SELECT_LINES
    } fdo_side_mode_e;

    // In-use indicator source
    typedef enum logic [1:0] {
        FDO_IU_SELECT,
        FDO_IU_OPT1,
        FDO_IU_OPT2,
        FDO_IU_OPT3
    } fdo_iu_mode_e;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register fields
    localparam int FDO_CFG_SEL_LSB = 0;
    localparam int FDO_CFG_HL_LSB = 2;
    localparam int FDO_CFG_SIDE_LSB = 4;
    localparam int FDO_CFG_IU_LSB = 6;
    localparam int FDO_CFG_RR_BIT = 8;
    localparam int FDO_CFG_RI_BIT = 9;
    localparam int FDO_CFG_DL_BIT = 10;
    localparam int FDO_CFG_NP_BIT = 11;
    localparam int FDO_CFG_ADDR_LSB = 12;
    localparam int FDO_CFG_POS_LSB = 16;
    localparam int FDO_CFG_W = 18;
    localparam logic [FDO_CFG_W-1:0] FDO_CFG_RESET = 18'h00000;

    // Register byte offsets
    localparam logic [11:0] FDO_OFS_CFG = 12'h000;
    localparam logic [11:0] FDO_OFS_STATUS = 12'h004;
    localparam logic [11:0] FDO_OFS_DOOR = 12'h008;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration carrier
    typedef struct packed {
        logic [1:0] daisy_position;
        logic spare;
        logic [2:0] multiplex_address;
        logic allow_write_protected;
        logic door_latch_enable;
        logic radial_index;
        logic radial_ready;
        fdo_iu_mode_e iu_mode;
        fdo_side_mode_e side_mode;
        fdo_hl_mode_e hl_mode;
        fdo_sel_mode_e sel_mode;
    } fdo_cfg_s;

    // Controller-side inputs, all active low on the cable
    typedef struct packed {
        logic [3:0] select_n;
        logic head_load_n;
        logic in_use_n;
        logic direction_n;
        logic step_n;
        logic side_n;
        logic write_gate_n;
    } fdo_ctl_s;

    // Mechanism status inputs, active high
    typedef struct packed {
        logic ready;
        logic index;
        logic protect;
        logic two_sided;
    } fdo_mech_s;

endpackage

// file: test/fdo_chk.sv
// Checker: status gating, door, write gate and APB handshake at the top ports.
// Assumes outputs follow cable and mechanism inputs three edges later.
`timescale 1ns/100ps
module fdo_chk (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire fdo_pkg::fdo_ctl_s CTL,
    input wire fdo_pkg::fdo_mech_s MECH,
    input wire logic WRITE_ENABLE,
    input wire logic STEP_PULSE,
    input wire logic READY_N,
    input wire logic INDEX_N,
    input wire logic READY_ALT_N,
    input wire logic INDEX_ALT_N,
    input wire logic PROTECT_N,
    input wire logic DOOR_LOCK,
    input wire logic TWO_SIDED_N
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////
    ready_gate_a: assert property (!READY_N |-> $past(MECH.ready, 3))
        else $error("ready shown without mechanism ready");
    ready_alt_a: assert property ($fell(READY_ALT_N) |-> $past(MECH.ready, 3))
        else $error("alternate ready without mechanism ready");
    index_gate_a: assert property (!INDEX_N |-> $past(MECH.index, 3))
        else $error("index shown without mechanism index");
    index_alt_a: assert property (!INDEX_ALT_N |-> $past(MECH.index, 3))
        else $error("alternate index without mechanism index");
    door_ready_a: assert property (DOOR_LOCK |-> $past(MECH.ready, 3))
        else $error("door lock on without ready");
    protect_rep_a: assert property (!PROTECT_N |-> $past(MECH.protect, 3))
        else $error("protect reported without protected disk");
    two_side_a: assert property ($fell(TWO_SIDED_N) |-> $past(MECH.two_sided, 3))
        else $error("two sided without two sided disk");
    write_gate_a: assert property (WRITE_ENABLE |-> !$past(CTL.write_gate_n, 3))
        else $error("write enabled without write gate");
    step_once_a: assert property (STEP_PULSE |=> !STEP_PULSE)
        else $error("step pulse longer than one cycle");
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not a single access cycle");
    apb_err_a: assert property (PSLVERR |-> PREADY)
        else $error("slave error without ready");
    cover property (PSLVERR);
    cover property (!READY_ALT_N && READY_N);
    cover property (DOOR_LOCK);
    cover property (STEP_PULSE);
endmodule

// file: test/fdo_ctl_model.sv
// Controller model: drives the active-low cable lines from the wanted levels.
// Assumes the bench changes the wanted levels just after a clock edge.
`timescale 1ns/100ps
module fdo_ctl_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire fdo_pkg::fdo_ctl_s want,
    output fdo_pkg::fdo_ctl_s ctl
);
    logic step_ok;
    fdo_pkg::fdo_ctl_s ctl_next;
    // No stepping while write gate is active
    assign step_ok = want.write_gate_n ? want.step_n : 1'h1;
    // Select line 1 travels with the address lines as one strobed word
    assign ctl_next = {want.select_n, want.head_load_n, want.in_use_n, want.direction_n,
        step_ok, want.side_n, want.write_gate_n};
    // Released lines idle high, active low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= '1;
        end else begin
            ctl <= ctl_next;
        end
    end
endmodule

// file: test/tb_fdo_option_logic.sv
// Bench: APB master, controller model and mechanism levels, self checking.
// Assumes the checker and the controller model compile before it.
`timescale 1ns/100ps
module tb_fdo_option_logic;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cur;
    fdo_pkg::fdo_ctl_s want, ctl;
    fdo_pkg::fdo_mech_s mech;
    logic head_load, stepper_on, head_side, write_enable, ready_n, index_n, ready_alt_n;
    logic index_alt_n, protect_n, in_use_lamp, door_lock, disk_change_n, two_sided_n;
    logic step_pulse, step_dir_in;
    int num_errors, compares;
    fdo_ctl_model fdo_ctl_model_inst (.clk(clk), .rst_n(rst_n), .want(want), .ctl(ctl));
    fdo_option_logic fdo_option_logic_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CTL(ctl), .MECH(mech), .HEAD_LOAD(head_load),
        .STEPPER_ON(stepper_on), .HEAD_SIDE(head_side), .STEP_PULSE(step_pulse),
        .STEP_DIR_IN(step_dir_in),
        .WRITE_ENABLE(write_enable), .READY_N(ready_n), .INDEX_N(index_n),
        .READY_ALT_N(ready_alt_n), .INDEX_ALT_N(index_alt_n), .PROTECT_N(protect_n),
        .IN_USE_LAMP(in_use_lamp), .DOOR_LOCK(door_lock), .DISK_CHANGE_N(disk_change_n),
        .TWO_SIDED_N(two_sided_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic drv(input logic [3:0] s, input logic [5:0] r, input logic [3:0] m);
        @(posedge clk);
        want <= {s, r};
        mech <= m;
        repeat (6) @(posedge clk);
    endtask
    task automatic row(input logic [31:0] c, input logic [3:0] s, input logic [5:0] r,
        input logic [3:0] m);
        if (c !== cur) begin
            drv(4'hf, 6'h3f, 4'h0);
            apb(1'h1, 12'h000, c);
            cur = c;
        end
        drv(s, r, m);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("disk_change_n", disk_change_n, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk("cfg reset", rd, 32'h0);
        apb(1'h1, 12'h000, 32'h12345);
        apb(1'h0, 12'h000, 32'h0);
        chk("cfg rw", rd, 32'h12345);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped err", er, 1'h1);
        chk("unmapped data", rd, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_mux;
        for (int a = 0; a < 8; a++) begin
            row(32'h5001, {~a[2:0], 1'h0}, 6'h3f, 4'h8);
            chk("mux select", head_load, a == 5);
        end
        row(32'h5001, 4'h5, 6'h3f, 4'h8);
        chk("mux strobe off", head_load, 1'h0);
        $display("t_mux done");
    endtask
    task automatic t_hl;
        logic [31:0] c[4] = '{32'h0, 32'h4, 32'h8, 32'hc};
        logic [3:0] s[4] = '{4'he, 4'he, 4'he, 4'hf};
        logic [5:0] r[4] = '{6'h3f, 6'h1f, 6'h3f, 6'h1f};
        logic [1:0] e[4] = '{2'h3, 2'h3, 2'h1, 2'h2};
        for (int i = 0; i < 4; i++) begin
            row(c[i], s[i], r[i], 4'h8);
            chk("heads/stepper", {head_load, stepper_on}, e[i]);
            chk("ready_n", ready_n, s[i][0]);
        end
        row(32'h4, 4'he, 6'h3f, 4'h8);
        chk("opt1 no head", {head_load, stepper_on, ready_n}, 3'h0);
        $display("t_hl done");
    endtask
    task automatic t_side;
        logic [31:0] c[7] = '{32'h0, 32'h0, 32'h10, 32'h10, 32'h22, 32'h22, 32'h22};
        logic [3:0] s[7] = '{4'he, 4'he, 4'he, 4'he, 4'hd, 4'he, 4'hb};
        logic [5:0] r[7] = '{6'h3d, 6'h3f, 6'h37, 6'h3d, 6'h3f, 6'h3f, 6'h3f};
        logic [1:0] e[7] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h0};
        for (int i = 0; i < 7; i++) begin
            row(c[i], s[i], r[i], 4'h8);
            chk("side/heads", {head_side, head_load}, e[i]);
        end
        $display("t_side done");
    endtask
    task automatic t_iu;
        logic [31:0] c[8] = '{32'h40, 32'h40, 32'h40, 32'h80, 32'h80, 32'hc0, 32'hc0, 32'h0};
        logic [3:0] s[8] = '{4'he, 4'hf, 4'hf, 4'hf, 4'he, 4'he, 4'hf, 4'hf};
        logic [5:0] r[8] = '{6'h3f, 6'h2f, 6'h3f, 6'h1f, 6'h3f, 6'h1f, 6'h2f, 6'h2f};
        logic [7:0] e = 8'h4b;
        for (int i = 0; i < 8; i++) begin
            row(c[i], s[i], r[i], 4'h0);
            chk("in use lamp", in_use_lamp, e[i]);
        end
        $display("t_iu done");
    endtask
    task automatic t_wp;
        logic [31:0] c[3] = '{32'h0, 32'h0, 32'h800};
        logic [3:0] m[3] = '{4'ha, 4'h8, 4'ha};
        logic [1:0] e[3] = '{2'h0, 2'h3, 2'h2};
        for (int i = 0; i < 3; i++) begin
            row(c[i], 4'he, 6'h3e, m[i]);
            chk("write/protect", {write_enable, protect_n}, e[i]);
        end
        $display("t_wp done");
    endtask
    task automatic t_status;
        row(32'h300, 4'hf, 6'h3f, 4'hd);
        chk("radial", {ready_alt_n, index_alt_n, ready_n, index_n}, 4'h3);
        row(32'h0, 4'hf, 6'h3f, 4'hd);
        chk("no radial", {ready_alt_n, index_alt_n, ready_n, index_n}, 4'hf);
        row(32'h0, 4'he, 6'h3f, 4'hd);
        chk("selected", {ready_n, index_n, two_sided_n}, 3'h0);
        row(32'h0, 4'he, 6'h3f, 4'hc);
        chk("single sided", two_sided_n, 1'h1);
        $display("t_status done");
    endtask
    task automatic t_door;
        logic [31:0] c[6] = '{32'h400, 32'h400, 32'h400, 32'h0, 32'h0, 32'h0};
        logic [3:0] s[6] = '{4'he, 4'hf, 4'hf, 4'he, 4'hf, 4'he};
        logic [5:0] e = 6'h0b;
        logic [5:0] m = 6'h1b;
        for (int i = 0; i < 6; i++) begin
            row(c[i], s[i], 6'h3f, {m[i], 3'h0});
            chk("door lock", door_lock, e[i]);
            apb(1'h0, 12'h008, 32'h0);
            chk("door reg", rd, e[i]);
        end
        $display("t_door done");
    endtask
    task automatic t_dc;
        logic [2:0] t[12] = '{3'h3, 3'h7, 3'h5, 3'h7, 3'h3, 3'h0, 3'h2, 3'h6, 3'h4, 3'h0,
            3'h6, 3'h3};
        row(32'h0, 4'he, 6'h3f, 4'h8);
        for (int i = 0; i < 12; i++) begin
            row(32'h0, {3'h7, ~t[i][2]}, 6'h3f, {t[i][1], 3'h0});
            chk("disk change", disk_change_n, t[i][0]);
        end
        apb(1'h0, 12'h004, 32'h0);
        chk("status reg", rd, 32'h4);
        $display("t_dc done");
    endtask
    task automatic t_step;
        int n;
        logic [3:0] s[3] = '{4'he, 4'he, 4'hf};
        logic [5:0] r[3] = '{6'h33, 6'h32, 6'h33};
        logic [1:0] e[3] = '{2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 3; i++) begin
            row(32'h0, s[i], 6'h3f, 4'h8);
            n = 0;
            @(posedge clk);
            want <= {s[i], r[i]};
            repeat (8) begin
                @(posedge clk);
                n += int'(step_pulse === 1'h1);
            end
            chk("step pulses", n, e[i]);
            chk("step dir", step_dir_in, 1'h1);
        end
        $display("t_step done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        want = '1;
        mech = '0;
        cur = 32'h0;
        num_errors = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_mux;
        t_hl;
        t_side;
        t_iu;
        t_wp;
        t_status;
        t_door;
        t_dc;
        t_step;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
endmodule
bind fdo_option_logic fdo_chk fdo_chk_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .CTL(CTL), .MECH(MECH),
    .WRITE_ENABLE(WRITE_ENABLE), .STEP_PULSE(STEP_PULSE), .READY_N(READY_N),
    .INDEX_N(INDEX_N), .READY_ALT_N(READY_ALT_N), .INDEX_ALT_N(INDEX_ALT_N),
    .PROTECT_N(PROTECT_N), .DOOR_LOCK(DOOR_LOCK), .TWO_SIDED_N(TWO_SIDED_N));
